// ---- pkg/ldsf_pkg.sv ----
/*
 * Shared constants, timing counts and the frame CRC step for the LED driver
 * serial frame and fault logic.
 * Assumes a 200 MHz core clock and an 8-bit CRC over every frame byte
 * except the sync byte.
 */
package ldsf_pkg;

    localparam int unsigned CLK_MHZ     = 200;
    localparam int unsigned T_FILTER_US = 4000;
    localparam int unsigned T_HICCUP_US = 1000;
    localparam int unsigned T_RETRY_US  = 32;
    localparam int unsigned FILTER_CYC  = T_FILTER_US * CLK_MHZ;
    localparam int unsigned HICCUP_CYC  = T_HICCUP_US * CLK_MHZ;
    localparam int unsigned RETRY_CYC   = T_RETRY_US * CLK_MHZ;

    localparam int unsigned NCH   = 16;
    localparam int unsigned NSYNC = 43;

    // positions inside the synchronised pin vector
    localparam int unsigned SY_RX    = 0;
    localparam int unsigned SY_OPEN  = 1;
    localparam int unsigned SY_SHORT = 17;
    localparam int unsigned SY_ROPEN = 33;
    localparam int unsigned SY_RSHRT = 34;
    localparam int unsigned SY_OTW   = 35;
    localparam int unsigned SY_OTSD  = 36;
    localparam int unsigned SY_EN    = 37;
    localparam int unsigned SY_UVLO  = 38;
    localparam int unsigned SY_DEV   = 39;

    localparam logic [7:0] SYNC_BYTE = 8'h55;
    localparam logic [2:0] SYNC_EDGES = 3'h5;
    localparam logic [7:0] CRC_POLY  = 8'h31;
    localparam logic [7:0] CRC_INIT  = 8'hff;
    localparam logic [7:0] CRC_XOR   = 8'h00;

    // command byte fields
    localparam int unsigned CMD_BCAST = 3;
    localparam int unsigned CMD_READ  = 2;

    localparam logic [7:0] ADDR_MAX   = 8'h33;
    localparam logic [7:0] ADDR_OPEN  = 8'h04;
    localparam logic [7:0] ADDR_SHORT = 8'h05;
    localparam logic [7:0] ADDR_MISC  = 8'h06;

    // bit positions in the miscellaneous fault register
    localparam int unsigned MISC_OTW   = 14;
    localparam int unsigned MISC_RSHRT = 13;
    localparam int unsigned MISC_ROPEN = 12;
    localparam int unsigned MISC_OTSD  = 11;

    // fixed bits of the reply status byte
    localparam logic [1:0] STAT_TOP = 2'h2;
    localparam logic [2:0] STAT_LOW = 3'h0;

    // short threshold in volts per select code
    localparam logic [2:0] THR_V_00 = 3'h2;
    localparam logic [2:0] THR_V_01 = 3'h3;
    localparam logic [2:0] THR_V_10 = 3'h4;
    localparam logic [2:0] THR_V_11 = 3'h5;

    // idle gap, in bit times shifted, before a frame is abandoned
    localparam int unsigned TIMEOUT_SHIFT = 5;

    function automatic logic [7:0] ldsf_crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int k = 0; k < 8; k++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
        end
        return r;
    endfunction : ldsf_crc8

endpackage : ldsf_pkg

// ---- core/ldsf_core.sv ----
/*
 * Serial frame interpreter and fault supervision of a 16-channel LED sink
 * driver: sync-based bit timing, frame decode, CRC, reply, fault flags and
 * the failsafe output.
 * Assumes an external register file on the same clock that takes writes
 * through wr_valid/wr_ready and answers rd_addr on rd_data in the same cycle.
 */
`timescale 1ns/1ps

module ldsf_core
    import ldsf_pkg::*;
#(
    parameter int unsigned FILT_CYC = FILTER_CYC,
    parameter int unsigned HIC_CYC  = HICCUP_CYC,
    parameter int unsigned RET_CYC  = RETRY_CYC
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    input  wire logic        rx_pin,
    input  wire logic [3:0]  target_select_field_pin,
    input  wire logic        uvlo_pin,
    input  wire logic        enable_pin,
    input  wire logic [15:0] open_det_pin,
    input  wire logic [15:0] short_det_pin,
    input  wire logic        current_ref_open_pin,
    input  wire logic        current_ref_short_pin,
    input  wire logic        overtemp_warn_pin,
    input  wire logic        overtemp_sd_pin,
    input  wire logic        latch_mode,
    input  wire logic        overtemp_warning_mask,
    input  wire logic [1:0]  short_threshold_select,
    input  wire logic [15:0] chan_request,
    input  wire logic        wr_ready,
    input  wire logic [15:0] rd_data,
    output logic             tx_out,
    output logic             wr_valid,
    output logic [7:0]       wr_addr,
    output logic [15:0]      wr_data,
    output logic [7:0]       rd_addr,
    output logic [15:0]      channel_on,
    output logic [15:0]      channel_open_flag,
    output logic [15:0]      channel_short_flag,
    output logic             current_ref_open_flag,
    output logic             current_ref_short_flag,
    output logic             overtemp_warning_flag,
    output logic             overtemp_shutdown_flag,
    output logic             failsafe_out_n,
    output logic             failsafe_oe,
    output logic [2:0]       short_threshold_volts
);

    typedef enum logic [3:0] {
        ST_HUNT, ST_SYNC, ST_WAIT, ST_RXB, ST_STOP,
        ST_CHECK, ST_PUSH, ST_FETCH, ST_CAP, ST_TX
    } ldsf_state_e;

    typedef struct packed {
        logic [NSYNC-1:0]       s1;
        logic [NSYNC-1:0]       s2;
        logic [NSYNC-1:0]       s3;
        logic [NSYNC-1:0]       f;
        logic                   rxp;
        ldsf_state_e            st;
        logic [16:0]            cnt;
        logic [2:0]             edges;
        logic [11:0]            blen;
        logic [12:0]            tim;
        logic [3:0]             bitn;
        logic [7:0]             sh;
        logic [3:0]             bidx;
        logic [7:0]             cmd;
        logic [7:0]             addr;
        logic [7:0]             crc;
        logic [7:0]             rxcrc;
        logic [63:0]            dbuf;
        logic [3:0]             widx;
        logic [7:0]             txb;
        logic [1:0]             tph;
        logic                   tx;
        logic [7:0]             rd_addr;
        logic [1:0]             fv;
        logic [23:0]            q0;
        logic [23:0]            q1;
        logic [NCH-1:0][19:0]   oc;
        logic [NCH-1:0][19:0]   sc;
        logic [NCH-1:0]         oact;
        logic [NCH-1:0]         sact;
        logic [NCH-1:0]         oflag;
        logic [NCH-1:0]         sflag;
        logic                   ref_lat;
        logic                   rof;
        logic                   rsf;
        logic                   otwf;
        logic                   otsf;
        logic [17:0]            ht;
        logic [NCH-1:0]         chon;
        logic                   fsn;
        logic [2:0]             thr;
    } ldsf_state_s;

    ldsf_state_s r;
    ldsf_state_s n;

    logic [NSYNC-1:0] raw;
    logic             rx_f;
    logic             fall;
    logic [15:0]      od;
    logic [15:0]      sd;
    logic             rop;
    logic             rsp;
    logic             otw;
    logic             ots;
    logic             en_f;
    logic             uvlo_f;
    logic [3:0]       dev_f;
    logic [3:0]       nbytes;
    logic [3:0]       crcpos;
    logic [7:0]       stat;
    logic             pop;
    logic             room;

    assign raw    = {target_select_field_pin, uvlo_pin, enable_pin, overtemp_sd_pin, overtemp_warn_pin,
                     current_ref_short_pin, current_ref_open_pin, short_det_pin,
                     open_det_pin, rx_pin};
    assign rx_f   = r.f[SY_RX];
    assign fall   = r.rxp & ~rx_f;
    assign od     = r.f[SY_OPEN +: NCH];
    assign sd     = r.f[SY_SHORT +: NCH];
    assign rop    = r.f[SY_ROPEN];
    assign rsp    = r.f[SY_RSHRT];
    assign otw    = r.f[SY_OTW];
    assign ots    = r.f[SY_OTSD];
    assign en_f   = r.f[SY_EN];
    assign uvlo_f = r.f[SY_UVLO];
    assign dev_f  = r.f[SY_DEV +: 4];
    assign nbytes = 4'h1 << r.cmd[1:0];
    assign crcpos = r.cmd[CMD_READ] ? 4'h2 : 4'h2 + nbytes;
    assign stat   = {STAT_TOP, |r.sflag, |r.oflag, r.fsn, STAT_LOW};
    assign pop    = r.fv[0] & wr_ready;
    assign room   = ~r.fv[1] | pop;

    always_comb begin
        logic [7:0]  b;
        logic        ld;
        logic [7:0]  ldb;
        logic [7:0]  ldc;
        logic [1:0]  ldph;
        logic        push;
        logic [23:0] push_w;
        logic [15:0] word;
        logic [15:0] clr_o;
        logic [15:0] clr_s;
        logic        clr_m;
        logic        ok;
        logic        hic;
        logic        fs;
        logic        oev;
        logic        sev;
        b      = '0;
        ld     = 1'b0;
        ldb    = '0;
        ldc    = '0;
        ldph   = '0;
        push   = 1'b0;
        push_w = '0;
        word   = '0;
        clr_o  = '0;
        clr_s  = '0;
        clr_m  = 1'b0;
        ok     = 1'b0;
        hic    = ~latch_mode;
        fs     = 1'b0;
        oev    = 1'b0;
        sev    = 1'b0;
        n      = r;
        // three-stage pin synchroniser, a change counts once stages 2 and 3 agree
        n.s1   = raw;
        n.s2   = r.s1;
        n.s3   = r.s2;
        n.f    = (r.f & (r.s2 ^ r.s3)) | (r.s2 & ~(r.s2 ^ r.s3));
        n.rxp  = rx_f;

        unique case (r.st)
            ST_HUNT: begin
                if (fall) begin
                    n.cnt   = '0;
                    n.edges = 3'h1;
                    n.st    = ST_SYNC;
                end
            end
            ST_SYNC: begin
                // five falling edges of the sync byte span eight bit times
                n.cnt = r.cnt + 17'h1;
                if (fall) begin
                    n.edges = r.edges + 3'h1;
                end
                if (fall && r.edges == SYNC_EDGES - 3'h1) begin
                    n.blen = n.cnt[14:3];
                    n.st   = (n.cnt[14:3] == '0) ? ST_HUNT : ST_WAIT;
                    n.cnt  = '0;
                    n.bidx = '0;
                    n.crc  = CRC_INIT;
                end else if (r.cnt[15]) begin
                    n.st = ST_HUNT;
                end
            end
            ST_WAIT: begin
                n.cnt = r.cnt + 17'h1;
                if (fall) begin
                    n.tim  = 13'(r.blen) + 13'(r.blen[11:1]) - 13'h1;
                    n.bitn = '0;
                    n.st   = ST_RXB;
                end else if (r.cnt > {r.blen, 5'h0}) begin
                    n.st = ST_HUNT;
                end
            end
            ST_RXB: begin
                if (r.tim != '0) begin
                    n.tim = r.tim - 13'h1;
                end else begin
                    b      = {rx_f, r.sh[7:1]};
                    n.sh   = b;
                    n.tim  = 13'(r.blen) - 13'h1;
                    n.bitn = r.bitn + 4'h1;
                    if (r.bitn == 4'h7) begin
                        n.bidx = r.bidx + 4'h1;
                        n.cnt  = '0;
                        n.st   = ST_WAIT;
                        if (r.bidx == 4'h0) begin
                            n.cmd = b;
                        end else if (r.bidx == 4'h1) begin
                            n.addr = b;
                        end else if (r.bidx != crcpos) begin
                            n.dbuf[{3'(r.bidx - 4'h2), 3'h0} +: 8] = b;
                        end
                        if (r.bidx == crcpos) begin
                            n.rxcrc = b;
                            n.st    = ST_STOP;
                        end else begin
                            n.crc = ldsf_crc8(r.crc, b);
                        end
                    end
                end
            end
            ST_STOP: begin
                if (r.tim != '0) begin
                    n.tim = r.tim - 13'h1;
                end else begin
                    n.st = ST_CHECK;
                end
            end
            ST_CHECK: begin
                ok = (r.rxcrc == (r.crc ^ CRC_XOR))
                   && (r.cmd[7:4] == dev_f || r.cmd[CMD_BCAST])
                   && !(r.cmd[CMD_BCAST] && r.cmd[CMD_READ]);
                n.widx = '0;
                if (!ok) begin
                    n.st = ST_HUNT;
                end else if (r.cmd[CMD_READ]) begin
                    ld  = 1'b1;
                    ldb = stat;
                    ldc = ldsf_crc8(CRC_INIT, stat);
                end else begin
                    n.st = ST_PUSH;
                end
            end
            ST_PUSH: begin
                if (r.widx[2:0] == 3'(nbytes[3:1])) begin
                    if (r.cmd[CMD_BCAST]) begin
                        n.st = ST_HUNT;
                    end else begin
                        ld  = 1'b1;
                        ldb = stat;
                        ldc = ldsf_crc8(CRC_INIT, stat);
                    end
                end else if (room) begin
                    push   = 1'b1;
                    push_w = {r.addr + 8'(r.widx[1:0]),
                              r.dbuf[{r.widx[1:0], 1'b1, 3'h0} +: 8],
                              r.dbuf[{r.widx[1:0], 1'b0, 3'h0} +: 8]};
                    n.widx = r.widx + 4'h1;
                end
            end
            ST_FETCH: begin
                n.rd_addr = r.addr + 8'(r.widx[3:1]);
                n.st      = ST_CAP;
            end
            ST_CAP: begin
                unique case (r.rd_addr)
                    ADDR_OPEN: begin
                        word  = r.oflag;
                        clr_o = {NCH{~r.widx[0]}};
                    end
                    ADDR_SHORT: begin
                        word  = r.sflag;
                        clr_s = {NCH{~r.widx[0]}};
                    end
                    ADDR_MISC: begin
                        word[MISC_OTW]   = r.otwf;
                        word[MISC_RSHRT] = r.rsf;
                        word[MISC_ROPEN] = r.rof;
                        word[MISC_OTSD]  = r.otsf;
                        clr_m            = ~r.widx[0];
                    end
                    default: word = rd_data;
                endcase
                b      = r.widx[0] ? word[15:8] : word[7:0];
                n.widx = r.widx + 4'h1;
                ld     = 1'b1;
                ldb    = b;
                ldc    = ldsf_crc8(r.crc, b);
                ldph   = 2'h1;
            end
            ST_TX: begin
                if (r.tim != '0) begin
                    n.tim = r.tim - 13'h1;
                end else begin
                    n.tim  = 13'(r.blen) - 13'h1;
                    n.bitn = r.bitn + 4'h1;
                    if (r.bitn < 4'h8) begin
                        n.tx = r.txb[r.bitn[2:0]];
                    end else if (r.bitn == 4'h8) begin
                        n.tx = 1'b1;
                    end else if (r.tph == 2'h2) begin
                        n.st = ST_HUNT;
                    end else if (r.cmd[CMD_READ] && r.widx < nbytes) begin
                        n.st = ST_FETCH;
                    end else begin
                        ld   = 1'b1;
                        ldb  = r.crc ^ CRC_XOR;
                        ldc  = r.crc;
                        ldph = 2'h2;
                    end
                end
            end
        endcase

        if (ld) begin
            n.txb  = ldb;
            n.crc  = ldc;
            n.tph  = ldph;
            n.tx   = 1'b0;
            n.bitn = '0;
            n.tim  = 13'(r.blen) - 13'h1;
            n.st   = ST_TX;
        end

        // two-entry write buffer, head drives the write port
        if (pop) begin
            n.q0 = r.q1;
            n.fv = {1'b0, r.fv[1]};
        end
        if (push) begin
            if (n.fv[0]) begin
                n.q1    = push_w;
                n.fv[1] = 1'b1;
            end else begin
                n.q0    = push_w;
                n.fv[0] = 1'b1;
            end
        end

        n.ht = (r.ht == 18'(HIC_CYC - 1)) ? '0 : r.ht + 18'h1;
        for (int i = 0; i < NCH; i++) begin
            oev = r.chon[i] && od[i] && r.oc[i] == 20'(FILT_CYC);
            sev = r.chon[i] && sd[i] && r.sc[i] == 20'(FILT_CYC);
            if (!(r.chon[i] && od[i])) begin
                n.oc[i] = '0;
            end else if (!oev) begin
                n.oc[i] = r.oc[i] + 20'h1;
            end
            if (!(r.chon[i] && sd[i])) begin
                n.sc[i] = '0;
            end else if (!sev) begin
                n.sc[i] = r.sc[i] + 20'h1;
            end
            // hiccup retry ends: fault gone if detector idle at window end
            if (hic && r.ht == 18'(RET_CYC - 1)) begin
                if (!od[i]) begin
                    n.oact[i] = 1'b0;
                end
                if (!sd[i]) begin
                    n.sact[i] = 1'b0;
                end
            end
            if (oev) begin
                n.oact[i] = 1'b1;
            end
            if (sev) begin
                n.sact[i] = 1'b1;
            end
            // set wins over a read clear; hiccup holds while fault persists
            n.oflag[i] = (r.oflag[i] & ~(clr_o[i] & ~(hic & r.oact[i]))) | oev;
            n.sflag[i] = (r.sflag[i] & ~(clr_s[i] & ~(hic & r.sact[i]))) | sev;
        end
        n.rof     = (r.rof & ~clr_m) | (rop & ~r.ref_lat);
        n.rsf     = (r.rsf & ~clr_m) | (rsp & ~r.ref_lat);
        n.ref_lat = r.ref_lat | rop | rsp;
        n.otwf    = (r.otwf & ~clr_m) | otw;
        n.otsf    = (r.otsf & ~clr_m) | ots;
        if (!en_f) begin
            n.oact    = '0;
            n.sact    = '0;
            n.oflag   = '0;
            n.sflag   = '0;
            n.oc      = '0;
            n.sc      = '0;
            n.ref_lat = 1'b0;
            n.rof     = 1'b0;
            n.rsf     = 1'b0;
            n.otwf    = 1'b0;
            n.otsf    = 1'b0;
        end
        for (int i = 0; i < NCH; i++) begin
            n.chon[i] = en_f && chan_request[i] && !ots && !n.ref_lat
                     && (!(n.oact[i] | n.sact[i]) || (hic && r.ht < 18'(RET_CYC)));
        end
        fs = (latch_mode ? |(n.oflag | n.sflag) : |(n.oact | n.sact))
           | n.ref_lat | (otw & ~overtemp_warning_mask) | ots;
        n.fsn = ~fs;

        unique case (short_threshold_select)
            2'h0: n.thr = THR_V_00;
            2'h1: n.thr = THR_V_01;
            2'h2: n.thr = THR_V_10;
            2'h3: n.thr = THR_V_11;
        endcase

        // undervoltage returns all but the synchroniser and short threshold to default, failsafe not driven
        if (uvlo_f) begin
            n     = '0;
            n.s1  = raw;
            n.s2  = r.s1;
            n.s3  = r.s2;
            n.f   = (r.f & (r.s2 ^ r.s3)) | (r.s2 & ~(r.s2 ^ r.s3));
            n.tx  = 1'b1;
            n.fsn = 1'b1;
            n.thr = r.thr;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r     <= '0;
            r.tx  <= 1'b1;
            r.fsn <= 1'b1;
        end else if (clk_en) begin
            r <= n;
        end
    end

    assign tx_out                 = r.tx;
    assign wr_valid               = r.fv[0];
    assign wr_addr                = r.q0[23:16];
    assign wr_data                = r.q0[15:0];
    assign rd_addr                = r.rd_addr;
    assign channel_on             = r.chon;
    assign channel_open_flag      = r.oflag;
    assign channel_short_flag     = r.sflag;
    assign current_ref_open_flag  = r.rof;
    assign current_ref_short_flag = r.rsf;
    assign overtemp_warning_flag  = r.otwf;
    assign overtemp_shutdown_flag = r.otsf;
    assign failsafe_out_n         = r.fsn;
    assign failsafe_oe            = ~r.fsn;
    assign short_threshold_volts  = r.thr;

endmodule : ldsf_core

// ---- sim/ldsf_chk.sv ----
/* checker on the ports of ldsf_core; assumes one clock domain and clk_en held high */
`timescale 1ns/1ps
module ldsf_chk (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        clk_en,
    input wire logic        uvlo_pin,
    input wire logic        overtemp_sd_pin,
    input wire logic        latch_mode,
    input wire logic [1:0]  short_threshold_select,
    input wire logic        wr_ready,
    input wire logic        wr_valid,
    input wire logic [7:0]  wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [15:0] channel_on,
    input wire logic [15:0] channel_open_flag,
    input wire logic        current_ref_short_flag,
    input wire logic        overtemp_shutdown_flag,
    input wire logic        failsafe_out_n,
    input wire logic [2:0]  short_threshold_volts
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence s_uvlo; uvlo_pin [*8]; endsequence
    sequence s_hot; overtemp_sd_pin [*8]; endsequence
    property p_uvlo; s_uvlo |->
        failsafe_out_n && channel_on == 16'h0 && channel_open_flag == 16'h0; endproperty
    a_uvlo: assert property (p_uvlo) else $error("undervoltage state wrong");
    property p_open; $rose(channel_open_flag[0]) |->
        ##[1:2] (!channel_on[0] && !failsafe_out_n); endproperty
    a_open: assert property (p_open) else $error("open fault wrong");
    property p_latch; latch_mode && channel_open_flag[0] ##1 channel_open_flag[0] |->
        !failsafe_out_n; endproperty
    a_latch: assert property (p_latch) else $error("latched flag without failsafe");
    property p_thr3; clk_en && short_threshold_select == 2'h1 |=>
        short_threshold_volts == 3'h3; endproperty
    a_thr3: assert property (p_thr3) else $error("threshold code 01 wrong");
    property p_thr8; clk_en && short_threshold_select[1] |=>
        short_threshold_volts == {2'h2, $past(short_threshold_select[0])}; endproperty
    a_thr8: assert property (p_thr8) else $error("threshold code 1x wrong");
    property p_ref; $rose(current_ref_short_flag) |->
        ##[0:2] (!failsafe_out_n && channel_on == 16'h0); endproperty
    a_ref: assert property (p_ref) else $error("reference fault wrong");
    property p_sd; s_hot |->
        overtemp_shutdown_flag && channel_on == 16'h0 && !failsafe_out_n; endproperty
    a_sd: assert property (p_sd) else $error("shutdown wrong");
    property p_wr; wr_valid && !wr_ready |=>
        wr_valid && $stable(wr_addr) && $stable(wr_data); endproperty
    a_wr: assert property (p_wr) else $error("head moved while stalled");
endmodule : ldsf_chk
bind ldsf_core ldsf_chk u_chk (.*);

// ---- sim/ldsf_regs.sv ----
/* register file model at the write and read ports; same clock as the core */
`timescale 1ns/1ps
module ldsf_regs (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        slow,
    input  wire logic [7:0]  rd_addr,
    output logic             wr_ready,
    output logic [15:0]      rd_data
);
    logic [7:0] cnt_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) cnt_reg <= 8'h00;
        else cnt_reg <= cnt_reg + 8'h01;
    end
    // slow mode takes one word in 256 cycles so the buffer fills
    assign wr_ready = slow ? (cnt_reg == 8'hff) : 1'b1;
    assign rd_data = {rd_addr, ~rd_addr};
endmodule : ldsf_regs

// ---- sim/ldsf_core_bench.sv ----
/* bench: host serial tasks send frames, replies, writes and fault pins are checked */
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
    $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module ldsf_core_bench;
    localparam int B = 100;
    int num_errors = 0, compares = 0;
    logic clk = 1'b0, nrst = 1'b0, rx_pin = 1'b1, uvlo_pin = 1'b0, enable_pin = 1'b1;
    logic latch_mode = 1'b0, overtemp_warning_mask = 1'b0, overtemp_warn_pin = 1'b0;
    logic overtemp_sd_pin = 1'b0, current_ref_short_pin = 1'b0, slow = 1'b0;
    logic [1:0] short_threshold_select = 2'h0;
    logic [15:0] open_det_pin = 16'h0000, short_det_pin = 16'h0000;
    logic tx_out, wr_valid, wr_ready, current_ref_short_flag, overtemp_warning_flag;
    logic overtemp_shutdown_flag, failsafe_out_n, failsafe_oe, current_ref_open_flag;
    logic [7:0] wr_addr, rd_addr;
    logic [15:0] wr_data, rd_data, channel_on, channel_open_flag, channel_short_flag;
    logic [2:0] short_threshold_volts, tv [4] = '{3'h2, 3'h3, 3'h4, 3'h5};
    logic [23:0] wq[$];
    ldsf_core #(.FILT_CYC(20), .HIC_CYC(64), .RET_CYC(8)) dut (
        .clk, .nrst, .clk_en(1'b1), .rx_pin, .target_select_field_pin(4'h3), .uvlo_pin, .enable_pin,
        .open_det_pin, .short_det_pin, .current_ref_open_pin(1'b0),
        .current_ref_short_pin, .overtemp_warn_pin, .overtemp_sd_pin, .latch_mode,
        .overtemp_warning_mask, .short_threshold_select, .chan_request(16'hffff), .wr_ready,
        .rd_data, .tx_out, .wr_valid, .wr_addr, .wr_data, .rd_addr, .channel_on,
        .channel_open_flag, .channel_short_flag, .current_ref_open_flag,
        .current_ref_short_flag, .overtemp_warning_flag, .overtemp_shutdown_flag,
        .failsafe_out_n, .failsafe_oe, .short_threshold_volts);
    ldsf_regs partner (.clk, .nrst, .slow, .rd_addr, .wr_ready, .rd_data);
    initial forever #2.5 clk = ~clk;
    always @(posedge clk) if (wr_valid && wr_ready) wq.push_back({wr_addr, wr_data});
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w
    function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
        c = c ^ b;
        for (int k = 0; k < 8; k++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h31 : {c[6:0], 1'b0};
        return c;
    endfunction : crc
    task automatic send(input logic [7:0] b);
        for (int i = -1; i < 9; i++) begin
            rx_pin = (i < 0) ? 1'b0 : (i > 7) ? 1'b1 : b[i];
            w(B);
        end
    endtask : send
    task automatic recv(output logic [7:0] b);
        int t;
        for (t = 0; t < 9000 && tx_out !== 1'b0; t++) w(1);
        if (t == 9000) begin num_errors++; conclude(); end
        w(B / 2);
        for (int i = 0; i < 8; i++) begin w(B); b[i] = tx_out; end
        w(B);
        `CHK(tx_out, 1'b1)
    endtask : recv
    task automatic frame(input logic [7:0] tq[$], input logic [7:0] eq[$]);
        logic [7:0] c, b;
        c = 8'hff;
        send(8'h55);
        foreach (tq[i]) begin send(tq[i]); c = crc(c, tq[i]); end
        send(c);
        c = 8'hff;
        foreach (eq[i]) begin recv(b); `CHK(b, eq[i]) c = crc(c, eq[i]); end
        recv(b);
        `CHK(b, c)
        w(B);
    endtask : frame
    task automatic conclude();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    initial begin
        w(16);
        nrst = 1'b1;
        w(8);
        for (int s = 0; s < 4; s++) begin
            short_threshold_select = s[1:0];
            w(3);
            `CHK(short_threshold_volts, tv[s])
        end
        slow = 1'b1;
        frame('{8'h32, 8'h10, 8'h34, 8'h12, 8'h78, 8'h56}, '{8'h88});
        `CHK(wq.size(), 2)
        `CHK({wq[0], wq[1]}, 48'h101234_115678)
        frame('{8'h35, 8'h20}, '{8'h88, 8'hdf, 8'h20});
        latch_mode = 1'b1;
        open_det_pin = 16'h0001;
        w(40);
        `CHK({channel_open_flag[0], channel_on[0], failsafe_out_n}, 3'h4)
        `CHK({failsafe_oe, current_ref_open_flag}, 2'h2)
        frame('{8'h35, 8'h04}, '{8'h90, 8'h01, 8'h00});
        `CHK({channel_on[0], failsafe_out_n}, 2'h1)
        enable_pin = 1'b0;
        open_det_pin = 16'h0000;
        w(10);
        enable_pin = 1'b1;
        w(10);
        `CHK(channel_on, 16'hffff)
        overtemp_warning_mask = 1'b1;
        overtemp_warn_pin = 1'b1;
        w(10);
        `CHK({overtemp_warning_flag, failsafe_out_n}, 2'h3)
        overtemp_warning_mask = 1'b0;
        w(3);
        `CHK(failsafe_out_n, 1'b0)
        overtemp_warn_pin = 1'b0;
        w(10);
        `CHK({overtemp_warning_flag, failsafe_out_n, channel_on}, 18'h3ffff)
        overtemp_sd_pin = 1'b1;
        w(10);
        `CHK({overtemp_shutdown_flag, failsafe_out_n, channel_on}, 18'h20000)
        overtemp_sd_pin = 1'b0;
        w(10);
        `CHK({overtemp_shutdown_flag, failsafe_out_n, channel_on}, 18'h3ffff)
        current_ref_short_pin = 1'b1;
        w(10);
        `CHK({current_ref_short_flag, failsafe_out_n, channel_on}, 18'h20000)
        current_ref_short_pin = 1'b0;
        w(10);
        `CHK(failsafe_out_n, 1'b0)
        uvlo_pin = 1'b1;
        w(10);
        `CHK({overtemp_warning_flag, current_ref_short_flag, failsafe_out_n}, 3'h1)
        `CHK(channel_on, 16'h0000)
        uvlo_pin = 1'b0;
        w(10);
        latch_mode = 1'b0;
        short_det_pin = 16'h0001;
        w(40);
        `CHK({channel_short_flag[0], failsafe_out_n}, 2'h2)
        short_det_pin = 16'h0000;
        w(80);
        `CHK({channel_short_flag[0], failsafe_out_n, channel_on[0]}, 3'h7)
        conclude();
    end
endmodule : ldsf_core_bench
